// File: hw/cop_clock_config.sv
// Clock output and PLL configuration register with AHB-Lite access and glitch-free output switching
`include "cop_regs.svh"
`default_nettype none
module cop_clock_config (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Candidate clocks for the clock output, asynchronous pins
  input wire logic irc40kClock,
  input wire logic lxtalClock,
  input wire logic irc8mClock,
  input wire logic hxtalClock,
  input wire logic pll_clock,
  // Clock output pin
  output logic clock_output,
  // Settings for the PLL and clock tree
  output cop_pkg::cop_pll_cfg_s pllCfg,
  output cop_pkg::cop_out_cfg_s outCfgActive,
  output logic switchPending
);

  // ---------------------------------------------------------------- bus slave
  logic [31:0] clock_config0_r;
  logic [31:0] clock_config0_nxt;
  logic wrPend_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  wire addrPhase = hsel && hready && (htrans == `COP_HTRANS_NONSEQ);
  wire hitCfg0 = (haddr[7:0] == `COP_CFG0_OFFSET) && (haddr[31:8] == 24'h000000);
  wire wrStart = addrPhase && hwrite && hitCfg0;
  wire rdStart = addrPhase && !hwrite && hitCfg0;

  // Only whole-word writes are taken; narrower ones leave the register unchanged
  wire wordSize = (hsize == 3'h2);

  // reserved bits kept by write mask
  wire [31:0] wrMerged = (hwdata & `COP_CFG0_WMASK) | (clock_config0_r & ~`COP_CFG0_WMASK);

  always_comb begin
    clock_config0_nxt = clock_config0_r;
    if (wrPend_r) begin
      clock_config0_nxt = wrMerged;
    end
  end

  // A read right behind a write sees the new value, so the register gets no wait state
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rdStart) begin
      rdata_nxt = clock_config0_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clock_config0_r <= `COP_CFG0_RESET;
    end else begin
      clock_config0_r <= clock_config0_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      wrPend_r <= wrStart && wordSize;
      rdata_r <= rdata_nxt;
    end
  end

  assign hrdata = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp = `COP_HRESP_OKAY;

  // ---------------------------------------------------------------- field view
  // halving select
  wire regHalve = clock_config0_r[`COP_HALVE_BIT];
  wire [2:0] regDiv = clock_config0_r[`COP_DIV_HI:`COP_DIV_LO];
  wire [2:0] regSel = clock_config0_r[`COP_SEL_HI:`COP_SEL_LO];
  // five-bit factor assembled from two places
  wire [4:0] mfCode = {clock_config0_r[`COP_MF4_BIT], clock_config0_r[`COP_MF_HI:`COP_MF_LO]};

  cop_pkg::cop_out_cfg_s regOutCfg;
  assign regOutCfg.pllHalveSel = regHalve;
  assign regOutCfg.divider = regDiv;
  assign regOutCfg.source = cop_pkg::cop_src_e'(regSel);

  // ---------------------------------------------------------------- PLL ratio
  logic [4:0] mfRatio;

  always_comb begin
    if (mfCode <= `COP_MF_LAST_PLUS2) begin
      mfRatio = 5'(mfCode + 5'h02);
    end else if (mfCode == `COP_MF_FLAT16) begin
      mfRatio = `COP_RATIO_16;
    end else if (mfCode >= `COP_MF_TOP31) begin
      mfRatio = `COP_RATIO_31;
    end else begin
      mfRatio = 5'(mfCode + 5'h01);
    end
  end

  assign pllCfg.pllMultFactor = mfCode;
  assign pllCfg.pllMultRatio = mfRatio;
  assign pllCfg.pllDoubleOff = clock_config0_r[`COP_DPLL_BIT];
  assign pllCfg.pllSourceSel = clock_config0_r[`COP_PLLSRC_BIT];
  assign pllCfg.apb2Prescale = clock_config0_r[`COP_APB2_HI:`COP_APB2_LO];
  assign pllCfg.apb1Prescale = clock_config0_r[`COP_APB1_HI:`COP_APB1_LO];
  assign pllCfg.ahbPrescale = clock_config0_r[`COP_AHB_HI:`COP_AHB_LO];
  assign pllCfg.sysClkSwitch = clock_config0_r[`COP_SCS_HI:`COP_SCS_LO];

  // ---------------------------------------------------------------- source sampling
  // Order: irc40k, lxtal, irc8m, hxtal, pll
  wire [4:0] pinClocks = {pll_clock, hxtalClock, irc8mClock, lxtalClock, irc40kClock};
  wire [4:0] pinLevel;
  wire [4:0] pinChange;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : gSync
      cop_pin_sync uSync (
        .clk(clk),
        .rst_b(rst_b),
        .pinIn(pinClocks[gi]),
        .level(pinLevel[gi]),
        .change(pinChange[gi])
      );
    end
  endgenerate

  // The system clock cannot be sampled by itself; the system source ticks on every cycle, and this toggle drives nothing
  logic sysToggle_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sysToggle_r <= 1'b0;
    end else begin
      sysToggle_r <= ~sysToggle_r;
    end
  end

  // ---------------------------------------------------------------- active settings
  cop_pkg::cop_out_cfg_s actCfg_r;
  cop_pkg::cop_out_cfg_s actCfg_nxt;
  cop_pkg::cop_state_e state_r;
  cop_pkg::cop_state_e state_nxt;
  logic prevOut_r;
  wire divOut;

  // halving select clear uses falling PLL edges only, which halves the edge rate; set takes both edges
  wire pllTick = actCfg_r.pllHalveSel ? pinChange[4] : (pinChange[4] && pinLevel[4]);

  logic srcTick;

  always_comb begin
    case (actCfg_r.source)
      cop_pkg::COP_SRC_IRC40K: srcTick = pinChange[0];
      cop_pkg::COP_SRC_LXTAL: srcTick = pinChange[1];
      cop_pkg::COP_SRC_SYS: srcTick = 1'b1;
      cop_pkg::COP_SRC_IRC8M: srcTick = pinChange[2];
      cop_pkg::COP_SRC_HXTAL: srcTick = pinChange[3];
      // PLL source follows the halving select
      cop_pkg::COP_SRC_PLL: srcTick = pllTick;
      // no clock or reserved code keeps the output low
      default: srcTick = 1'b0;
    endcase
  end

  wire cfgDiffers = (regOutCfg != actCfg_r);
  wire fellNow = prevOut_r && !divOut;
  wire idleSrc = (actCfg_r.source == cop_pkg::COP_SRC_NONE) || (actCfg_r.source == cop_pkg::COP_SRC_RSVD);

  // new settings load only as the output falls, or at once while no clock or the reserved code is active, so no high pulse is cut short
  wire swapNow = (state_r == cop_pkg::COP_ST_WAIT) && !divOut && (fellNow || idleSrc);

  always_comb begin
    state_nxt = state_r;
    actCfg_nxt = actCfg_r;
    case (state_r)
      cop_pkg::COP_ST_RUN: begin
        if (cfgDiffers) begin
          state_nxt = cop_pkg::COP_ST_WAIT;
        end
      end
      cop_pkg::COP_ST_WAIT: begin
        if (swapNow) begin
          actCfg_nxt = regOutCfg;
          state_nxt = cop_pkg::COP_ST_RUN;
        end
      end
      default: begin
        state_nxt = cop_pkg::COP_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= cop_pkg::COP_ST_RUN;
      actCfg_r <= cop_pkg::cop_out_cfg_s'(7'h00);
      prevOut_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      actCfg_r <= actCfg_nxt;
      prevOut_r <= divOut;
    end
  end

  // power-of-two division of the selected source
  cop_out_div uDiv (
    .clk(clk),
    .rst_b(rst_b),
    .restart(swapNow),
    .tick(srcTick && !swapNow),
    .divSel(actCfg_r.divider),
    .clkOut(divOut)
  );

  assign clock_output = divOut;
  assign outCfgActive = actCfg_r;
  assign switchPending = (state_r == cop_pkg::COP_ST_WAIT);

endmodule : cop_clock_config
`default_nettype wire

// File: hw/cop_regs.svh
// Offsets, field positions, reset values and ratio constants of the clock output and PLL configuration
`ifndef COP_REGS_SVH
`define COP_REGS_SVH

`define COP_CFG0_OFFSET 8'h04
`define COP_CFG0_RESET 32'h0002_0000
// Bits that software can change; 23:22 and the switch status 3:2 read as stored zero
`define COP_CFG0_WMASK 32'hFF3F_FFF3

`define COP_HALVE_BIT 31
`define COP_DIV_HI 30
`define COP_DIV_LO 28
`define COP_MF4_BIT 27
`define COP_SEL_HI 26
`define COP_SEL_LO 24
`define COP_MF_HI 21
`define COP_MF_LO 18
`define COP_DPLL_BIT 17
`define COP_PLLSRC_BIT 16
`define COP_APB2_HI 13
`define COP_APB2_LO 11
`define COP_APB1_HI 10
`define COP_APB1_LO 8
`define COP_AHB_HI 7
`define COP_AHB_LO 4
`define COP_SCS_HI 1
`define COP_SCS_LO 0

`define COP_MF_LAST_PLUS2 5'h0E
`define COP_MF_FLAT16 5'h0F
`define COP_MF_TOP31 5'h1E
`define COP_RATIO_16 5'h10
`define COP_RATIO_31 5'h1F

`define COP_HTRANS_NONSEQ 2'h2
`define COP_HRESP_OKAY 1'h0

`endif

// File: hw/cop_pkg.sv
// Types shared by the clock output and PLL configuration block
`default_nettype none
package cop_pkg;

  // Clock output source codes
  typedef enum logic [2:0] {
    COP_SRC_NONE   = 3'h0,
    COP_SRC_RSVD   = 3'h1,
    COP_SRC_IRC40K = 3'h2,
    COP_SRC_LXTAL  = 3'h3,
    COP_SRC_SYS    = 3'h4,
    COP_SRC_IRC8M  = 3'h5,
    COP_SRC_HXTAL  = 3'h6,
    COP_SRC_PLL    = 3'h7
  } cop_src_e;

  // Switch sequencer states
  typedef enum logic [1:0] {
    COP_ST_RUN  = 2'b01,
    COP_ST_WAIT = 2'b10
  } cop_state_e;

  // Clock output settings that take effect together
  typedef struct packed {
    logic pllHalveSel;
    logic [2:0] divider;
    cop_src_e source;
  } cop_out_cfg_s;

  // Fields handed to the PLL and clock tree
  typedef struct packed {
    logic [4:0] pllMultFactor;
    logic [4:0] pllMultRatio;
    logic pllDoubleOff;
    logic pllSourceSel;
    logic [2:0] apb2Prescale;
    logic [2:0] apb1Prescale;
    logic [3:0] ahbPrescale;
    logic [1:0] sysClkSwitch;
  } cop_pll_cfg_s;

endpackage : cop_pkg
`default_nettype wire

// File: hw/cop_pin_sync.sv
// Three-flop synchroniser with agreement filter for one clock pin
`default_nettype none
module cop_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pin side
  input wire logic pinIn,
  // Filtered level and a pulse on each accepted change
  output logic level,
  output logic change
);

  logic meta_r;
  logic sync2_r;
  logic sync3_r;
  logic level_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      meta_r <= pinIn;
      sync2_r <= meta_r;
      sync3_r <= sync2_r;
    end
  end

  // Only a level that held for two samples is accepted
  wire agree = (sync2_r == sync3_r);
  wire levelNxt = agree ? sync3_r : level_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level_r <= 1'b0;
    end else begin
      level_r <= levelNxt;
    end
  end

  assign level = level_r;
  assign change = levelNxt ^ level_r;

endmodule : cop_pin_sync
`default_nettype wire

// File: hw/cop_out_div.sv
// Power-of-two edge divider that builds the clock output
`default_nettype none
module cop_out_div (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic restart,
  input wire logic tick,
  input wire logic [2:0] divSel,
  // Output
  output logic clkOut
);

  logic [6:0] count_r;
  logic [6:0] count_nxt;
  logic out_r;
  logic out_nxt;

  // Each half period of the output spans 2**divSel source edges
  wire [6:0] lastCount = 7'((8'h01 << divSel) - 8'h01);
  wire wrap = tick && (count_r == lastCount);

  always_comb begin
    count_nxt = count_r;
    out_nxt = out_r;
    if (restart) begin
      count_nxt = 7'h00;
      out_nxt = 1'b0;
    end else if (wrap) begin
      count_nxt = 7'h00;
      out_nxt = ~out_r;
    end else if (tick) begin
      count_nxt = 7'(count_r + 7'h01);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= 7'h00;
      out_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      out_r <= out_nxt;
    end
  end

  assign clkOut = out_r;

endmodule : cop_out_div
`default_nettype wire

// File: bench/cop_clock_config_monitor.sv
// Concurrent checks on the ports of the clock output and PLL configuration block
`default_nettype none
module cop_clock_config_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Clock side
  input wire logic clock_output,
  input wire cop_pkg::cop_pll_cfg_s pllCfg,
  input wire cop_pkg::cop_out_cfg_s outCfgActive,
  input wire logic switchPending
);
  logic wrPend_r;
  logic rdPend_r;
  wire addrHit;
  wire [4:0] mf;
  wire [4:0] mr;
  wire sysDiv0;
  wire sysDiv1;
  assign addrHit = hsel && hready && htrans == 2'h2 && haddr == 32'h0000_0004;
  assign mf = pllCfg.pllMultFactor;
  assign mr = pllCfg.pllMultRatio;
  assign sysDiv0 = outCfgActive.source == cop_pkg::COP_SRC_SYS && outCfgActive.divider == 3'h0;
  assign sysDiv1 = outCfgActive.source == cop_pkg::COP_SRC_SYS && outCfgActive.divider == 3'h1;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
    end else begin
      wrPend_r <= addrHit && hwrite && hsize == 3'h2;
      rdPend_r <= addrHit && !hwrite;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_okay; hresp == 1'b0 && hreadyout == 1'b1; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
  property p_wrFactor; wrPend_r |=> mf == {$past(hwdata[27]), $past(hwdata[21:18])}; endproperty
  a_wrFactor: assert property (p_wrFactor) else $error("factor not taken from write");
  property p_rdFactor; rdPend_r |-> {hrdata[27], hrdata[21:18]} == mf && hrdata[23:22] == 2'h0; endproperty
  a_rdFactor: assert property (p_rdFactor) else $error("read data disagrees with factor");
  property p_lowRatio; mf <= 5'h0E |-> mr == mf + 5'h02; endproperty
  a_lowRatio: assert property (p_lowRatio) else $error("low ratio wrong");
  property p_midRatio; mf inside {[5'h0F:5'h1B]} |-> mr == (mf == 5'h0F ? 5'h10 : mf + 5'h01); endproperty
  a_midRatio: assert property (p_midRatio) else $error("middle ratio wrong");
  property p_topRatio; mf >= 5'h1D |-> mr == (mf == 5'h1D ? 5'h1E : 5'h1F); endproperty
  a_topRatio: assert property (p_topRatio) else $error("top ratio wrong");
  property p_noneLow; outCfgActive.source == cop_pkg::COP_SRC_NONE |-> !clock_output; endproperty
  a_noneLow: assert property (p_noneLow) else $error("output not low without source");
  property p_sysDiv1; sysDiv0 [*3] |-> clock_output != $past(clock_output); endproperty
  a_sysDiv1: assert property (p_sysDiv1) else $error("system clock output not toggling");
  property p_sysDiv2; sysDiv1 [*3] ##0 $changed(clock_output) |=> $stable(clock_output); endproperty
  a_sysDiv2: assert property (p_sysDiv2) else $error("divide by two wrong");
  c_write: cover property (wrPend_r);
  c_sys: cover property (sysDiv0 [*4]);
  c_pll: cover property (outCfgActive.source == cop_pkg::COP_SRC_PLL);
  c_pend: cover property (switchPending);
endmodule : cop_clock_config_monitor
bind cop_clock_config cop_clock_config_monitor mon_u (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .clock_output(clock_output), .pllCfg(pllCfg),
  .outCfgActive(outCfgActive), .switchPending(switchPending));
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the clock output and PLL configuration block
`include "cop_regs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] cyc = 32'h0;
  logic rdLive = 1'b0;
  logic [31:0] e, d, r;
  logic [31:0] expQ[$];
  int err_total = 0;
  int total_checks = 0;
  int i;
  wire logic hready, hresp, clock_output, switchPending;
  wire logic [31:0] hrdata;
  wire cop_pkg::cop_pll_cfg_s pllCfg;
  wire cop_pkg::cop_out_cfg_s outCfg;
  always #10 clk = ~clk;
  // Source pins come from a free counter, each slower than a quarter of clk
  cop_clock_config dut_u (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .irc40kClock(cyc[4]), .lxtalClock(cyc[2]), .irc8mClock(cyc[5]), .hxtalClock(cyc[6]), .pll_clock(cyc[3]),
    .clock_output(clock_output), .pllCfg(pllCfg), .outCfgActive(outCfg), .switchPending(switchPending));
  function automatic logic [4:0] ratioOf(input logic [4:0] c);
    if (c <= 5'h0E) return c + 5'h02;
    if (c == 5'h0F) return 5'h10;
    if (c >= 5'h1E) return 5'h1F;
    return c + 5'h01;
  endfunction : ratioOf
  task automatic report_and_stop;
    if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic cmpWord(input string nm, input logic [31:0] ex, input logic [31:0] g);
    total_checks++;
    if (g !== ex) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, ex, g);
    end
  endtask : cmpWord
  task automatic cmpCount(input string nm, input int ex, input int g);
    total_checks++;
    if (g != ex) begin
      err_total++;
      $display("wrong value %s expected %0d seen %0d", nm, ex, g);
    end
  endtask : cmpCount
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] v, input logic [2:0] sz);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge clk); while (hready !== 1'b1);
  endtask : xfer
  task automatic rd(input logic [31:0] a, input logic [31:0] ex);
    expQ.push_back(ex);
    xfer(1'b0, a, 32'h0, 3'h2);
  endtask : rd
  task automatic setOut(input logic h, input logic [2:0] dv, input logic [2:0] s, input int half);
    int n;
    int k;
    logic last;
    xfer(1'b1, 32'h4, {h, dv, 1'b0, s, 24'h02_0000}, 3'h2);
    repeat (2) @(posedge clk);
    n = 0;
    while (switchPending !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    cmpWord("active", 32'({h, dv, s}), 32'(outCfg));
    if (half == 0) begin
      last = 1'b0;
      repeat (300) begin
        @(posedge clk);
        last = last | clock_output;
      end
      cmpWord("idle", 32'h0, 32'(last));
    end else begin
      // First intervals may be cut short by the swap
      for (k = 0; k < 3; k++) begin
        last = clock_output;
        n = 0;
        do begin
          @(posedge clk);
          n++;
        end while (clock_output === last && n < 2000);
      end
      cmpCount("half period", half, n);
    end
  endtask : setOut
  always @(posedge clk) begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'd40000) begin
      err_total++;
      report_and_stop();
    end
  end
  always @(posedge clk) begin
    rdLive <= hsel && hready && htrans == 2'h2 && !hwrite;
    if (rdLive) begin
      e = expQ.pop_front();
      cmpWord("hrdata", e, hrdata);
      cmpWord("ratio", 32'(ratioOf({e[27], e[21:18]})), 32'(pllCfg.pllMultRatio));
    end
  end
  initial begin
    void'($urandom(32'hEFC2));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(32'h4, `COP_CFG0_RESET);
    cmpWord("pin", 32'h0, 32'(clock_output));
    xfer(1'b1, 32'h8, 32'hFFFF_FFFF, 3'h2);
    rd(32'h8, 32'h0);
    rd(32'h4, `COP_CFG0_RESET);
    // Reserved bits 23:22 always written as zero
    for (i = 0; i < 32; i++) begin
      r = $urandom();
      d = {4'h0, i[4], 5'h00, i[3:0], r[17:0]};
      xfer(1'b1, 32'h4, d, 3'h2);
      rd(32'h4, d & `COP_CFG0_WMASK);
      cmpWord("factor", 32'({d[27], d[21:18]}), 32'(pllCfg.pllMultFactor));
      cmpWord("pll fields", 32'({d[17:16], d[13:4], d[1:0]}), 32'(pllCfg[13:0]));
    end
    xfer(1'b1, 32'h4, 32'hFFFF_FFFF, 3'h0);
    rd(32'h4, d & `COP_CFG0_WMASK);
    for (i = 0; i < 8; i++) setOut(1'b0, i[2:0], 3'h4, 1 << i);
    setOut(1'b0, 3'h0, 3'h2, 16);
    setOut(1'b0, 3'h1, 3'h3, 8);
    setOut(1'b0, 3'h0, 3'h5, 32);
    setOut(1'b0, 3'h0, 3'h6, 64);
    setOut(1'b0, 3'h0, 3'h7, 16);
    setOut(1'b1, 3'h0, 3'h7, 8);
    setOut(1'b1, 3'h2, 3'h7, 32);
    setOut(1'b0, 3'h0, 3'h0, 0);
    setOut(1'b0, 3'h0, 3'h1, 0);
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
